// File: inc/ldp_pkg.sv
// Purpose: Shared constants of the latching digital I/O port
// Assumes: 32-bit register bus, byte addresses, one register per word
// Notes:   Reset values give inputs, pull-ups on, all interrupts masked

`default_nettype none

package ldp_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CH_N = 8;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_INPUT = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_DIR = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PULL_POL = 6'h0c;
  localparam logic [ADDR_W-1:0] OFS_PULL_EN = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_INVERT = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_LATCH = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_OUT_TYPE = 6'h1c;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 6'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OUT_TYPE_BIT = 0;
  localparam int LINE_LEVEL_BIT = 8;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [CH_N-1:0] RST_OUTPUT = 8'hff;
  localparam logic [CH_N-1:0] RST_DIR = 8'hff;
  localparam logic [CH_N-1:0] RST_PULL_POL = 8'hff;
  localparam logic [CH_N-1:0] RST_PULL_EN = 8'hff;
  localparam logic [CH_N-1:0] RST_INVERT = 8'h00;
  localparam logic [CH_N-1:0] RST_LATCH = 8'h00;
  localparam logic [CH_N-1:0] RST_INT_MASK = 8'hff;
  localparam logic RST_OUT_TYPE = 1'h0;
  localparam logic [CH_N-1:0] RST_PIN_OE = 8'h00;
  localparam logic [CH_N-1:0] RST_PULL_UP_ON = 8'hff;
  localparam logic [CH_N-1:0] RST_PULL_DN_ON = 8'h00;

  // Output drive types
  localparam logic OT_PUSH_PULL = 1'h0;
  localparam logic OT_OPEN_DRAIN = 1'h1;

endpackage

`default_nettype wire

// File: inc/ldp_ch_if.sv
// Purpose: Signals between the port core and one channel tracker
// Assumes: One instance per channel
// Notes:   Level is the terminal value after inversion

`timescale 1ns/1ps
`default_nettype none

interface ldp_ch_if;
  logic lvl;
  logic latch;
  logic mask;
  logic rd_clr;
  logic value;
  logic pend;
  modport top (output lvl, output latch, output mask, output rd_clr,
               input value, input pend);
  modport ch (input lvl, input latch, input mask, input rd_clr,
              output value, output pend);
endinterface

`default_nettype wire

// File: rtl/ldp_channel.sv
// Purpose: Change-of-state tracking, latching and pending flag, one channel
// Assumes: Level input is synchronous to clock
// Notes:   Reference level is taken on the first cycle after reset

`timescale 1ns/1ps
`default_nettype none

module ldp_channel
  import ldp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Core side
  ldp_ch_if.ch chn
);

  typedef struct packed {
    logic primed;
    logic base;
    logic held;
    logic cap;
    logic pend;
  } ldp_ch_state_t;

  ldp_ch_state_t st;
  ldp_ch_state_t next_st;
  logic ev;

  assign ev = st.primed && (chn.lvl != st.base);

  always_comb begin
    next_st = st;
    next_st.primed = 1'b1;
    if (!st.primed) begin
      next_st.base = chn.lvl;
    end else if (!chn.latch) begin
      next_st.held = 1'b0;
      next_st.pend = ev && !chn.mask;
      if (chn.rd_clr) begin
        next_st.base = chn.lvl;
        next_st.pend = 1'b0;
      end
    end else begin
      if (!st.held && ev) begin
        next_st.held = 1'b1;
        next_st.cap = chn.lvl;
      end
      next_st.pend = !chn.mask && (st.pend || (!st.held && ev));
      if (chn.rd_clr) begin
        // The level read now becomes the reference, so a change in this
        // very cycle is reported by the read data and is not lost
        next_st.held = 1'b0;
        next_st.base = chn.lvl;
        next_st.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign chn.value = (chn.latch && st.held) ? st.cap : chn.lvl;
  assign chn.pend = st.pend;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_live_event;
    (!chn.latch && !chn.mask && !chn.rd_clr && ev) |=> chn.pend;
  endproperty
  a_live_event: assert property (p_live_event)
    else $error("live change did not raise pending");

  property p_withdraw;
    (!chn.latch && st.primed && !ev) |=> !chn.pend;
  endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("reverted live input kept pending");

  property p_read_clear;
    chn.rd_clr |=> !chn.pend;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("input read did not clear pending");

  property p_capture;
    (chn.latch && !st.held && ev && !chn.rd_clr)
      |=> (st.held && st.cap == $past(chn.lvl));
  endproperty
  a_capture: assert property (p_capture)
    else $error("latched change was not captured");

  property p_hold;
    (chn.latch && !chn.mask && chn.pend && !chn.rd_clr) |=> chn.pend;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched pending dropped without a read");

  property p_masked;
    chn.mask |=> !chn.pend;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked channel shows pending");

  c_capture: cover property (chn.latch && !st.held && ev);
  c_revert_held: cover property (st.held && chn.lvl != st.cap);

endmodule

`default_nettype wire

// File: rtl/ldp_port.sv
// Purpose: Eight-channel digital I/O port with change-of-state interrupt
// Assumes: Avalon-MM slave with waitrequest; pins synchronous to clock
// Notes:   Every output but the constant-low irq_out comes from a flip-flop; interrupt is open-drain
//
// Function
// - Direction bit per channel, 0 output, 1 input.
// - Pull polarity bit per channel, 0 pull-down, 1 pull-up.
// - Pull enable bit per channel, 0 disconnected, 1 connected.
// - Pull forced off for output channels under open-drain type.
// - Inversion bit per channel, 1 presents complemented level.
// - Latch bit per channel, 0 transparent, 1 latched capture.
// - Non-latched reads show live level; change raises pending if unmasked.
// - Input register read clears pending change status.
// - Non-latched pending withdrawn when level returns before a read.
// - Latched change raises pending and captures the new value.
// - Latched revert keeps pending and captured value until read.
// - After reading a captured value, next read shows present level.
// - Latch mode switches change read source immediately.
// - One global output type bit, 0 push-pull, 1 open-drain.
// - Mask bit per channel, 1 suppresses that channel's interrupt.
// - Interrupt status, one pending bit per channel in bits 7:0, shared line level in bit 8.
// - Shareable interrupt line, active until all sources clear.
// - Each per-channel setting written as one 8-bit word.
// - Settings read back with the same encoding.
// - Reset gives inputs, outputs 1s, pull-ups, masked, push-pull.
// - Output register writes stored even while channel is input.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module ldp_port
  import ldp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Channel terminals
  input wire logic [CH_N-1:0] pin_in,
  output logic [CH_N-1:0] pin_out,
  output logic [CH_N-1:0] pin_oe,
  output logic [CH_N-1:0] pull_up_on,
  output logic [CH_N-1:0] pull_dn_on,
  // Shared interrupt line, open-drain, active low
  input wire logic irq_in,
  output logic irq_out,
  output logic irq_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CH_N-1:0] out;
    logic [CH_N-1:0] dir;
    logic [CH_N-1:0] ppol;
    logic [CH_N-1:0] pen;
    logic [CH_N-1:0] inv;
    logic [CH_N-1:0] latch;
    logic [CH_N-1:0] mask;
    logic otype;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic [CH_N-1:0] pin_out;
    logic [CH_N-1:0] pin_oe;
    logic [CH_N-1:0] pu;
    logic [CH_N-1:0] pd;
    logic irq_oe;
  } ldp_port_state_t;

  localparam ldp_port_state_t RST_STATE = '{
    out: RST_OUTPUT,
    dir: RST_DIR,
    ppol: RST_PULL_POL,
    pen: RST_PULL_EN,
    inv: RST_INVERT,
    latch: RST_LATCH,
    mask: RST_INT_MASK,
    otype: RST_OUT_TYPE,
    waitreq: 1'h1,
    rdata: 32'h0000_0000,
    pin_out: RST_OUTPUT,
    pin_oe: RST_PIN_OE,
    pu: RST_PULL_UP_ON,
    pd: RST_PULL_DN_ON,
    irq_oe: 1'h0
  };

  ldp_port_state_t st;
  ldp_port_state_t next_st;

  logic [CH_N-1:0] ch_value;
  logic [CH_N-1:0] ch_pend;
  logic [ADDR_W-1:0] word_addr;
  logic rd_take;
  logic wr_take;
  logic rd_input;
  logic [CH_N-1:0] wbyte;
  logic [CH_N-1:0] od_out;
  logic [DATA_W-1:0] rmux;

  // ----------------------------------------------------------------
  // Channel trackers
  // ----------------------------------------------------------------
  ldp_ch_if chn [CH_N] ();

  genvar gi;
  generate
    for (gi = 0; gi < CH_N; gi++) begin : g_ch
      assign chn[gi].lvl = pin_in[gi] ^ st.inv[gi];
      assign chn[gi].latch = st.latch[gi];
      assign chn[gi].mask = st.mask[gi];
      assign chn[gi].rd_clr = rd_input;
      assign ch_value[gi] = chn[gi].value;
      assign ch_pend[gi] = chn[gi].pend;
      ldp_channel u_ch (
        .clock(clock),
        .nrst(nrst),
        .chn(chn[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A read is taken while waitrequest is high, a write while it is low; the answer follows
  // one cycle later with waitrequest low for exactly one cycle.
  assign word_addr = {avs_address[ADDR_W-1:2], 2'b00};
  assign rd_take = avs_read && st.waitreq;
  assign wr_take = avs_write && !st.waitreq && avs_byteenable[0];
  // Clearing at the sampling edge keeps the read data and the cleared
  // status consistent; a whole-port read clears every channel at once
  assign rd_input = rd_take && (word_addr == OFS_INPUT);
  assign wbyte = avs_writedata[CH_N-1:0];

  always_comb begin
    rmux = '0;
    unique case (word_addr)
      OFS_INPUT: rmux[CH_N-1:0] = ch_value;
      OFS_OUTPUT: rmux[CH_N-1:0] = st.out;
      OFS_DIR: rmux[CH_N-1:0] = st.dir;
      OFS_PULL_POL: rmux[CH_N-1:0] = st.ppol;
      OFS_PULL_EN: rmux[CH_N-1:0] = st.pen;
      OFS_INVERT: rmux[CH_N-1:0] = st.inv;
      OFS_LATCH: rmux[CH_N-1:0] = st.latch;
      OFS_OUT_TYPE: rmux[OUT_TYPE_BIT] = st.otype;
      OFS_INT_MASK: rmux[CH_N-1:0] = st.mask;
      OFS_INT_STAT: begin
        rmux[CH_N-1:0] = ch_pend;
        rmux[LINE_LEVEL_BIT] = irq_in;
      end
      default: rmux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign od_out = ~st.dir & {CH_N{st.otype == OT_OPEN_DRAIN}};

  always_comb begin
    next_st = st;
    next_st.waitreq = !((avs_read || avs_write) && st.waitreq);
    if (rd_take) begin
      next_st.rdata = rmux;
    end
    if (wr_take) begin
      unique case (word_addr)
        OFS_OUTPUT: next_st.out = wbyte;
        OFS_DIR: next_st.dir = wbyte;
        OFS_PULL_POL: next_st.ppol = wbyte;
        OFS_PULL_EN: next_st.pen = wbyte;
        OFS_INVERT: next_st.inv = wbyte;
        OFS_LATCH: next_st.latch = wbyte;
        OFS_OUT_TYPE: next_st.otype = wbyte[OUT_TYPE_BIT];
        OFS_INT_MASK: next_st.mask = wbyte;
        default: next_st.otype = st.otype;
      endcase
    end
    // Open-drain drives only the low level; the high level is left to
    // the external pull, so the output value is fixed at zero there
    next_st.pin_out = (st.otype == OT_OPEN_DRAIN) ? '0 : st.out;
    next_st.pin_oe = ~st.dir
      & ({CH_N{st.otype == OT_PUSH_PULL}} | ~st.out);
    next_st.pu = st.pen & st.ppol & ~od_out;
    next_st.pd = st.pen & ~st.ppol & ~od_out;
    next_st.irq_oe = |ch_pend;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign pin_out = st.pin_out;
  assign pin_oe = st.pin_oe;
  assign pull_up_on = st.pu;
  assign pull_dn_on = st.pd;
  assign irq_oe = st.irq_oe;
  // The line is only ever pulled low; other boards share it
  assign irq_out = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_one_wait;
    ((avs_read || avs_write) && st.waitreq) |=> !avs_waitrequest ##1
      avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("waitrequest not low for exactly one cycle");

  property p_dir_store;
    (wr_take && word_addr == OFS_DIR)
      |=> (st.dir == $past(wbyte)) ##1 (pin_oe == ($past(~st.dir)
      & ({CH_N{$past(st.otype) == OT_PUSH_PULL}} | ~$past(st.out))));
  endproperty
  a_dir_store: assert property (p_dir_store)
    else $error("direction write not reflected on drive enables");

  property p_od_pull_off;
    (st.otype == OT_OPEN_DRAIN) |=> ((pull_up_on | pull_dn_on)
      & ~$past(st.dir)) == '0;
  endproperty
  a_od_pull_off: assert property (p_od_pull_off)
    else $error("pull left on for open-drain output");

  property p_pull_select;
    (st.otype == OT_PUSH_PULL) |=> (pull_up_on == ($past(st.pen)
      & $past(st.ppol))) && (pull_dn_on == ($past(st.pen) & ~$past(st.ppol)));
  endproperty
  a_pull_select: assert property (p_pull_select)
    else $error("pull selection mismatch");

  property p_preload;
    (wr_take && word_addr == OFS_OUTPUT) |=> st.out == $past(wbyte);
  endproperty
  a_preload: assert property (p_preload)
    else $error("output register write not stored");

  property p_input_no_drive;
    (st.dir == '1) ##1 (st.dir == '1) |-> pin_oe == '0;
  endproperty
  a_input_no_drive: assert property (p_input_no_drive)
    else $error("input channel drives its terminal");

  property p_irq_or;
    1'b1 |=> irq_oe == $past(|ch_pend);
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("interrupt line not the OR of status bits");

  property p_read_back;
    (rd_take && word_addr == OFS_LATCH) |=> !avs_waitrequest
      && avs_readdata == {24'h00_0000, $past(st.latch)};
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("setting read back differs");

  property p_input_read;
    (rd_take && word_addr == OFS_INPUT && st.latch == '0)
      |=> avs_readdata[CH_N-1:0] == $past(pin_in ^ st.inv);
  endproperty
  a_input_read: assert property (p_input_read)
    else $error("live input read mismatch");

  property p_stat_read;
    (rd_take && word_addr == OFS_INT_STAT)
      |=> avs_readdata[CH_N-1:0] == $past(ch_pend);
  endproperty
  a_stat_read: assert property (p_stat_read)
    else $error("status read mismatch");

  property p_pin_out;
    1'b1 |=> pin_out == (($past(st.otype) == OT_OPEN_DRAIN) ? 8'h00
      : $past(st.out));
  endproperty
  a_pin_out: assert property (p_pin_out)
    else $error("drive value does not follow output type");

  // A write without lane 0 must leave every setting untouched
  property p_be_refuse;
    (avs_write && !st.waitreq && !avs_byteenable[0])
      |=> {st.out, st.dir, st.ppol, st.pen, st.inv, st.latch, st.mask,
      st.otype} == $past({st.out, st.dir, st.ppol, st.pen, st.inv,
      st.latch, st.mask, st.otype});
  endproperty
  a_be_refuse: assert property (p_be_refuse)
    else $error("write without byte lane 0 changed a setting");

  property p_dir_read;
    (rd_take && word_addr == OFS_DIR) |=> !avs_waitrequest
      && avs_readdata == {24'h00_0000, $past(st.dir)};
  endproperty
  a_dir_read: assert property (p_dir_read)
    else $error("direction read back differs");

  property p_type_read;
    (rd_take && word_addr == OFS_OUT_TYPE)
      |=> avs_readdata == {31'h0, $past(st.otype)};
  endproperty
  a_type_read: assert property (p_type_read)
    else $error("output type read back differs");

  property p_irq_hold;
    (ch_pend != 8'h00) |=> irq_oe;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt released while a source is pending");

  property p_unmapped;
    (rd_take && word_addr > OFS_INT_STAT) |=> avs_readdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address read nonzero");

  c_input_read: cover property (rd_input && ch_pend != '0);
  c_irq_rise: cover property (!irq_oe ##1 irq_oe);
  c_od_drive: cover property (st.otype == OT_OPEN_DRAIN && pin_oe != '0);

endmodule

`default_nettype wire

// File: verif/ldp_wire_model.sv
// Purpose: Terminals and shared interrupt wire seen from outside the port
// Assumes: Far end of each terminal is driven through ext_val and ext_en
// Notes:   A terminal nobody drives or pulls toggles every cycle

`timescale 1ns/1ps
`default_nettype none

module ldp_wire_model
  import ldp_pkg::*;
(
  // Clock
  input wire logic clock,
  // Device side
  input wire logic [CH_N-1:0] pin_out,
  input wire logic [CH_N-1:0] pin_oe,
  input wire logic [CH_N-1:0] pull_up_on,
  input wire logic [CH_N-1:0] pull_dn_on,
  input wire logic irq_out,
  input wire logic irq_oe,
  // Far side
  input wire logic [CH_N-1:0] ext_val,
  input wire logic [CH_N-1:0] ext_en,
  input wire logic other_irq,
  // Resolved levels
  output logic [CH_N-1:0] pin_lvl,
  output logic irq_wire
);
  logic [CH_N-1:0] float_lvl;

  // A floating line must not look like a steady level to the port
  always_ff @(posedge clock) begin
    float_lvl <= (float_lvl === 8'h55) ? 8'haa : 8'h55;
  end

  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_en[i]) pin_lvl[i] = ext_val[i];
      else if (pull_up_on[i]) pin_lvl[i] = 1'b1;
      else if (pull_dn_on[i]) pin_lvl[i] = 1'b0;
      else pin_lvl[i] = float_lvl[i];
    end
  end

  // External pull-up holds the shared line high when nobody pulls it
  assign irq_wire = (irq_oe ? irq_out : 1'b1) & ~other_irq;
endmodule

`default_nettype wire

// File: verif/ldp_port_bench.sv
// Purpose: Self-checking bench of the latching digital I/O port
// Assumes: Bench is the host on the bus and the far end of every terminal
// Notes:   Pin events are given 3 cycles to reach status before a read

`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  failures++; $display("BAD %0t got %h want %h", $time, g, e); end end

module ldp_port_bench
  import ldp_pkg::*;
;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata, q, d;
  logic avs_waitrequest, irq_out, irq_oe, irq_wire;
  logic other_irq = 1'b0;
  logic [CH_N-1:0] pin_lvl, pin_out, pin_oe, pull_up_on, pull_dn_on;
  logic [CH_N-1:0] ext_val = 8'h00;
  logic [CH_N-1:0] ext_en = 8'hff;
  logic [7:0] r;
  int failures = 0;
  int n_compared = 0;
  int i;
  int seed = 32'he545;
  logic [ADDR_W-1:0] ofs [8] = '{OFS_OUTPUT, OFS_DIR, OFS_PULL_POL,
    OFS_PULL_EN, OFS_INVERT, OFS_LATCH, OFS_INT_MASK, OFS_OUT_TYPE};
  logic [7:0] rst_v [8] = '{RST_OUTPUT, RST_DIR, RST_PULL_POL, RST_PULL_EN,
    RST_INVERT, RST_LATCH, RST_INT_MASK, {7'h0, RST_OUT_TYPE}};

  ldp_port ldp_port_i (.clock(clock), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_up_on(pull_up_on), .pull_dn_on(pull_dn_on),
    .irq_in(irq_wire), .irq_out(irq_out), .irq_oe(irq_oe));

  ldp_wire_model ldp_wire_model_i (.clock(clock), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_on(pull_up_on), .pull_dn_on(pull_dn_on),
    .irq_out(irq_out), .irq_oe(irq_oe), .ext_val(ext_val), .ext_en(ext_en),
    .other_irq(other_irq), .pin_lvl(pin_lvl), .irq_wire(irq_wire));

  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One edge passes first so a request never rises where one fell
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= wd;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      failures++;
      $display("BAD %0t bus answer missing", $time);
      stop_test;
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v);
    bus(1'b1, a, {24'h0, v});
  endtask

  // Whole port is always read, never a single bit
  task automatic rd(input logic [ADDR_W-1:0] a);
    bus(1'b0, a, '0);
  endtask

  function automatic logic [7:0] pull_on(logic [7:0] e, p, dr, logic ot);
    return e & p & ~(~dr & {8{ot}});
  endfunction

  task automatic pins(input logic [7:0] o, dr, p, e, input logic ot);
    repeat (3) @(posedge clock);
    `CHK(pin_oe, ot ? ~dr & ~o : ~dr)
    `CHK(pin_out, ot ? 8'h00 : o)
    `CHK(pull_up_on, pull_on(e, p, dr, ot))
    `CHK(pull_dn_on, pull_on(e, ~p, dr, ot))
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    pins(8'hff, 8'hff, 8'hff, 8'hff, 1'b0);
    `CHK(irq_oe, 1'b0)
    for (i = 0; i < 8; i++) begin
      rd(ofs[i]);
      `CHK(q, {24'h0, rst_v[i]})
    end
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      r = (ofs[i % 8] == OFS_OUT_TYPE) ? {7'h0, d[0]} : d[7:0];
      bus(1'b1, ofs[i % 8], d);
      rd(ofs[i % 8]);
      `CHK(q, {24'h0, r})
    end
    for (i = 0; i < 8; i++) wr(ofs[i], rst_v[i]);
    avs_byteenable <= 4'he;
    wr(OFS_DIR, 8'h00);
    avs_byteenable <= 4'hf;
    rd(OFS_DIR);
    `CHK(q, 32'h0ff)
    rd(6'h3c);
    `CHK(q, 32'h000)
    // Terminals left to the pulls, then driven by the port
    ext_en <= 8'h00;
    wr(OFS_PULL_POL, 8'h0f);
    pins(8'hff, 8'hff, 8'h0f, 8'hff, 1'b0);
    rd(OFS_INPUT);
    `CHK(q, 32'h00f)
    wr(OFS_PULL_EN, 8'h00);
    pins(8'hff, 8'hff, 8'h0f, 8'h00, 1'b0);
    wr(OFS_PULL_EN, 8'hff);
    wr(OFS_OUTPUT, 8'h5a);
    pins(8'h5a, 8'hff, 8'h0f, 8'hff, 1'b0);
    wr(OFS_DIR, 8'hf0);
    pins(8'h5a, 8'hf0, 8'h0f, 8'hff, 1'b0);
    rd(OFS_INPUT);
    `CHK(q, 32'h00a)
    wr(OFS_OUT_TYPE, 8'h01);
    pins(8'h5a, 8'hf0, 8'h0f, 8'hff, 1'b1);
    wr(OFS_DIR, 8'hff);
    wr(OFS_OUT_TYPE, 8'h00);
    wr(OFS_PULL_POL, 8'hff);
    ext_en <= 8'hff;
    // Change-of-state events, transparent channels
    wr(OFS_INT_MASK, 8'h00);
    rd(OFS_INPUT);
    ext_val <= 8'h01;
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h001)
    `CHK(irq_oe, 1'b1)
    `CHK(irq_out, 1'b0)
    rd(OFS_INPUT);
    `CHK(q, 32'h001)
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h100)
    `CHK(irq_oe, 1'b0)
    ext_val <= 8'h03;
    repeat (3) @(posedge clock);
    ext_val <= 8'h01;
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h100)
    wr(OFS_INT_MASK, 8'h80);
    ext_val <= 8'h81;
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h100)
    ext_val <= 8'h01;
    repeat (3) @(posedge clock);
    wr(OFS_INT_MASK, 8'h00);
    ext_val <= 8'h31;
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h030)
    rd(OFS_INPUT);
    other_irq <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h000)
    `CHK(irq_oe, 1'b0)
    other_irq <= 1'b0;
    // Latched channels: a pulse is held until read
    wr(OFS_LATCH, 8'hff);
    rd(OFS_INPUT);
    ext_val <= 8'h39;
    repeat (3) @(posedge clock);
    ext_val <= 8'h31;
    repeat (3) @(posedge clock);
    rd(OFS_INT_STAT);
    `CHK(q, 32'h008)
    rd(OFS_INPUT);
    `CHK(q, 32'h039)
    rd(OFS_INPUT);
    `CHK(q, 32'h031)
    ext_val <= 8'h35;
    repeat (3) @(posedge clock);
    ext_val <= 8'h31;
    repeat (3) @(posedge clock);
    wr(OFS_LATCH, 8'h00);
    rd(OFS_INPUT);
    `CHK(q, 32'h031)
    // Random levels under random inversion
    wr(OFS_INT_MASK, 8'hff);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(OFS_INVERT, d[15:8]);
      ext_val <= d[7:0];
      repeat (3) @(posedge clock);
      rd(OFS_INPUT);
      `CHK(q, {24'h0, d[7:0] ^ d[15:8]})
    end
    stop_test;
  end
endmodule

`default_nettype wire
